// ### src/kme_pkg.sv
package kme_pkg;

  // key classes presented by the key matrix scanner
  typedef enum logic [2:0] {
    KME_KEY_LETTER,
    KME_KEY_DIGIT,
    KME_KEY_SYMBOL,
    KME_KEY_MODE,
    KME_KEY_FUNC
  } kme_key_class_t;

  // mode key identifiers carried in the key index when class is mode
  localparam logic [5:0] KME_MODE_CONTROL   = 6'h00;
  localparam logic [5:0] KME_MODE_SHIFT     = 6'h01;
  localparam logic [5:0] KME_MODE_UPPER     = 6'h02;
  localparam logic [5:0] KME_MODE_ALTERNATE = 6'h03;
  localparam logic [5:0] KME_MODE_KEYPAD    = 6'h04;
  localparam logic [5:0] KME_MODE_CLACKER   = 6'h05;

  // character code anchors
  localparam logic [7:0] KME_CODE_LOWER_A = 8'h61;
  localparam logic [7:0] KME_CODE_UPPER_A = 8'h41;
  localparam logic [7:0] KME_CODE_CTRL_A  = 8'h01;
  localparam logic [7:0] KME_CODE_DIGIT_0 = 8'h30;
  localparam logic [5:0] KME_LETTER_LAST  = 6'h19;
  localparam logic [5:0] KME_DIGIT_LAST   = 6'h09;

  // reset values of the latching toggles
  localparam logic KME_RST_UPPER   = 1'b0;
  localparam logic KME_RST_KEYPAD  = 1'b0;
  localparam logic KME_RST_CLACKER = 1'b0;

  // click length in cycles
  localparam int unsigned KME_CLICK_CYCLES = 16;

  // key event from the scanner
  typedef struct packed {
    logic           press;
    kme_key_class_t kclass;
    logic [5:0]     index;
    logic [7:0]     plain_code;
    logic [7:0]     shift_code;
  } kme_key_t;

  // encoded character toward the host
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic       alt_code;
  } kme_char_t;

endpackage : kme_pkg

// ### src/kme_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for a vector of pin levels
module kme_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // kme_sync

`default_nettype wire

// ### src/kme_encoder.sv
// Behaviour
// (R1) control plus letter gives codes 01 to 1A
// (R2) shift gives shifted characters and alternate codes
// (R3) uppercase latch toggles; uppercase letters, digits unchanged
// (R4) keypad toggle latched selects hex, else edit
// (R5) clacker toggle released clicks on each press
// (R6) no modifier active means normal mode
// (R7) normal letters give lowercase codes
// (R8) normal digits give their own digit code
// (R9) symbols follow shift for dual legends
// (R10) alternate modifier changes no code
// (R11) control beats shift and uppercase on letters
`timescale 1ns/1ps
`default_nettype none

module kme_encoder #(
  parameter int unsigned CLICK_CYCLES = kme_pkg::KME_CLICK_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              control_held,
  input  wire logic              shift_held,
  input  wire logic              alternate_modifier,
  input  wire kme_pkg::kme_key_t key_in,
  output kme_pkg::kme_char_t     char_out,
  output logic                   uppercase_latch,
  output logic                   keypad_hex_mode,
  output logic                   clacker_up,
  output logic                   click
);

  // modifiers arrive from switches, so synchronise them
  logic [2:0] mod_s;
  logic       ctrl_s;
  logic       shift_s;

  kme_sync #(.WIDTH(3)) u_mod_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({control_held, shift_held, alternate_modifier}),
    .dout    (mod_s)
  );

  assign ctrl_s  = mod_s[2];
  assign shift_s = mod_s[1];
  // mod_s[0] is the alternate key: synchronised but unused in any code path

  localparam int unsigned CNT_W = $clog2(CLICK_CYCLES + 1);

  logic             upper_q;
  logic             keypad_q;
  logic             clacker_q;
  logic [CNT_W-1:0] click_cnt_q;
  logic             is_press;
  logic             mode_press;
  logic             upper_hit;
  logic             keypad_hit;
  logic             clacker_hit;
  logic             letter_hit;
  logic             digit_hit;
  logic             symbol_hit;
  logic             func_hit;
  logic             valid_q;
  logic [7:0]       code_q;
  logic             alt_q;

  // a press of one key class; every accept path starts from this test
  function automatic logic class_press(input kme_pkg::kme_key_t       k,
                                       input kme_pkg::kme_key_class_t c);
    class_press = k.press && (k.kclass == c);
  endfunction

  assign is_press   = key_in.press;
  assign mode_press = class_press(key_in, kme_pkg::KME_KEY_MODE);

  // one strobe per latching key so each latch sees a plain enable
  assign upper_hit   = mode_press && (key_in.index == kme_pkg::KME_MODE_UPPER);
  assign keypad_hit  = mode_press && (key_in.index == kme_pkg::KME_MODE_KEYPAD);
  assign clacker_hit = mode_press && (key_in.index == kme_pkg::KME_MODE_CLACKER);

  // accepted presses; a letter index past Z is refused rather than wrapped
  assign letter_hit = class_press(key_in, kme_pkg::KME_KEY_LETTER)
                   && (key_in.index <= kme_pkg::KME_LETTER_LAST);
  assign digit_hit  = class_press(key_in, kme_pkg::KME_KEY_DIGIT);
  assign symbol_hit = class_press(key_in, kme_pkg::KME_KEY_SYMBOL);
  assign func_hit   = class_press(key_in, kme_pkg::KME_KEY_FUNC);

  // letter code selection; control checked first
  function automatic logic [7:0] letter_code(input logic [5:0] idx,
                                             input logic       ctrl,
                                             input logic       upper);
    logic [7:0] off;
    off = {2'b00, idx};
    if (ctrl)
      letter_code = kme_pkg::KME_CODE_CTRL_A + off; // R1 R11
    else if (upper)
      letter_code = kme_pkg::KME_CODE_UPPER_A + off; // R2 R3
    else
      letter_code = kme_pkg::KME_CODE_LOWER_A + off; // R6 R7
  endfunction

  // uppercase latch leaves digits alone, only shift alters them
  function automatic logic [7:0] digit_code(input kme_pkg::kme_key_t k,
                                            input logic              shift);
    if (shift)
      digit_code = k.shift_code; // R2
    else if (k.index <= kme_pkg::KME_DIGIT_LAST)
      digit_code = kme_pkg::KME_CODE_DIGIT_0 + {2'b00, k.index}; // R3 R8
    else
      digit_code = k.plain_code;
  endfunction

  // dual-legend keys: shift chooses between the two table entries
  function automatic logic [7:0] pick_code(input logic [7:0] plain,
                                           input logic [7:0] shifted,
                                           input logic       shift);
    pick_code = shift ? shifted : plain;
  endfunction

  // uppercase latch flips on each press, whatever else is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      upper_q <= kme_pkg::KME_RST_UPPER;
    end else if (upper_hit) begin
      upper_q <= ~upper_q; // R3
    end
  end

  // keypad toggle: set means hex keypad, clear means edit keypad
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      keypad_q <= kme_pkg::KME_RST_KEYPAD;
    end else if (keypad_hit) begin
      keypad_q <= ~keypad_q; // R4
    end
  end

  // clacker toggle: clear means released, so clicks are on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clacker_q <= kme_pkg::KME_RST_CLACKER;
    end else if (clacker_hit) begin
      clacker_q <= ~clacker_q; // R5
    end
  end

  // valid is high the cycle after each cycle of an accepted press; mode keys and refused letters give none
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= letter_hit || digit_hit || symbol_hit || func_hit;
    end
  end

  // code holds until the next accepted press; alternate modifier not consulted
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      code_q <= '0;
    end else if (letter_hit) begin
      code_q <= letter_code(key_in.index, ctrl_s, shift_s | upper_q); // R10
    end else if (digit_hit) begin
      code_q <= digit_code(key_in, shift_s);
    end else if (symbol_hit) begin
      code_q <= pick_code(key_in.plain_code, key_in.shift_code, shift_s); // R9
    end else if (func_hit) begin
      // function tables live outside; the alternate set is flagged instead
      code_q <= pick_code(key_in.plain_code, key_in.shift_code, shift_s); // R2
    end
  end

  // alternate-set flag rides only with a function key press
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alt_q <= 1'b0;
    end else begin
      alt_q <= func_hit && shift_s; // R2
    end
  end

  // flops go straight onto the output, no logic in between
  assign char_out = '{valid: valid_q, code: code_q, alt_code: alt_q};

  // click pulse, any key press while the clacker is released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      click_cnt_q <= '0;
      click       <= 1'b0;
    end else if (is_press && !clacker_q) begin
      click_cnt_q <= CNT_W'(CLICK_CYCLES - 1); // R5
      click       <= 1'b1;
    end else if (click_cnt_q != '0) begin
      click_cnt_q <= click_cnt_q - CNT_W'(1);
      click       <= 1'b1;
    end else begin
      click <= 1'b0;
    end
  end

  // status outputs trail their latches by a cycle so they come from flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uppercase_latch <= kme_pkg::KME_RST_UPPER;
    end else begin
      uppercase_latch <= upper_q; // R3
    end
  end

  // keypad mode out, high for hex
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      keypad_hex_mode <= kme_pkg::KME_RST_KEYPAD;
    end else begin
      keypad_hex_mode <= keypad_q; // R4
    end
  end

  // clacker_up is high while the clacker is released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clacker_up <= ~kme_pkg::KME_RST_CLACKER;
    end else begin
      clacker_up <= ~clacker_q; // R5
    end
  end

endmodule // kme_encoder

`default_nettype wire

// ### tb/kme_encoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the encoder
module kme_encoder_assertions (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               control_held,
  input wire logic               shift_held,
  input wire logic               alternate_modifier,
  input wire kme_pkg::kme_key_t  key_in,
  input wire kme_pkg::kme_char_t char_out,
  input wire logic               uppercase_latch,
  input wire logic               keypad_hex_mode,
  input wire logic               clacker_up,
  input wire logic               click
);
  // a letter press that the design must accept
  wire logic ltr = key_in.press && key_in.kclass == kme_pkg::KME_KEY_LETTER
                   && key_in.index <= kme_pkg::KME_LETTER_LAST;
  wire logic mk = key_in.press && key_in.kclass == kme_pkg::KME_KEY_MODE;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  letter_valid_a: assert property (ltr |=> char_out.valid) else $error("no valid");
  mode_silent_a: assert property (mk |=> !char_out.valid) else $error("mode valid");
  // control must have been seen through the synchroniser for two edges
  ctrl_code_a: assert property (ltr && control_held && $past(control_held)
    && $past(control_held, 2) && !$past(rst) && !$past(rst, 2)
    |=> char_out.code == kme_pkg::KME_CODE_CTRL_A + $past(key_in.index)) else $error("ctrl");
  keypad_toggle_a: assert property (mk && key_in.index == kme_pkg::KME_MODE_KEYPAD
    |=> ##1 keypad_hex_mode != $past(keypad_hex_mode)) else $error("keypad");
  upper_toggle_a: assert property (mk && key_in.index == kme_pkg::KME_MODE_UPPER
    |=> ##1 $changed(uppercase_latch)) else $error("upper");
  clacker_toggle_a: assert property (mk && key_in.index == kme_pkg::KME_MODE_CLACKER
    |=> ##1 clacker_up == !$past(clacker_up)) else $error("clacker");
  // skip a cycle after any press, the clacker output lags its state
  click_start_a: assert property (ltr && clacker_up && !$past(key_in.press)
    |=> click) else $error("click");
  click_hold_a: assert property ($rose(click) |-> click[*8]) else $error("short");
  refused_letter_a: assert property (key_in.press
    && key_in.kclass == kme_pkg::KME_KEY_LETTER && key_in.index > kme_pkg::KME_LETTER_LAST
    |=> !char_out.valid) else $error("refused letter valid");
  alt_only_func_a: assert property (!(key_in.press
    && key_in.kclass == kme_pkg::KME_KEY_FUNC) |=> !char_out.alt_code) else $error("alt");
endmodule // kme_encoder_assertions
`default_nettype wire

// ### tb/kme_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module kme_host_model (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire kme_pkg::kme_char_t char_in,
  output logic [7:0]             last_code,
  output logic [15:0]            n_rx
);
  // code is only trusted in the valid cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      n_rx <= 16'h0000;
    end else if (char_in.valid) begin
      n_rx <= n_rx + 16'h0001;
      last_code <= char_in.code;
    end
  end
endmodule // kme_host_model
`default_nettype wire

// ### tb/kme_encoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module kme_encoder_test;
  localparam kme_pkg::kme_key_class_t LT = kme_pkg::KME_KEY_LETTER;
  localparam kme_pkg::kme_key_class_t MD = kme_pkg::KME_KEY_MODE;
  localparam kme_pkg::kme_key_class_t DG = kme_pkg::KME_KEY_DIGIT;
  logic               sys_clk = 0, rst = 1, control_held = 0, shift_held = 0;
  logic               alternate_modifier = 0, uppercase_latch, keypad_hex_mode, clacker_up, click;
  kme_pkg::kme_key_t  key_in = '0;
  kme_pkg::kme_char_t char_out;
  logic [7:0]         last_code;
  logic [15:0]        n_rx;
  int                 errors = 0, n_compared = 0, n_exp = 0;
  // {control, shift, alternate, code of letter A}
  logic [10:0]        rows [5] = '{11'h061, 11'h161, 11'h241, 11'h401, 11'h701};
  kme_encoder i_dut (.sys_clk, .rst, .control_held, .shift_held, .alternate_modifier,
    .key_in, .char_out, .uppercase_latch, .keypad_hex_mode, .clacker_up, .click);
  kme_host_model i_host (.sys_clk, .rst, .char_in(char_out), .last_code, .n_rx);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // press stays up so presses can run back to back
  task automatic key(input kme_pkg::kme_key_class_t c, input logic [5:0] i,
                     input logic [7:0] pc, sc, e, input logic v = 1);
    key_in = '{1'b1, c, i, pc, sc};
    tick(1);
    chk({char_out.valid, v ? char_out.code : 8'h00}, {v, e});
    n_exp += v;
  endtask
  task automatic results;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // whole run is well under 1500 cycles
  initial begin
    tick(3000);
    errors++;
    results();
  end
  initial begin
    tick(12);
    rst = 0;
    tick(1);
    chk({char_out.valid, uppercase_latch, keypad_hex_mode, clacker_up, click}, 16'h2);
    foreach (rows[r]) begin
      {control_held, shift_held, alternate_modifier} = rows[r][10:8];
      tick(3);
      for (int i = 0; i < 26; i++) key(LT, 6'(i), 8'h00, 8'h00, rows[r][7:0] + 8'(i));
      key_in.press = 0;
    end
    $display("rows done");
    {control_held, shift_held, alternate_modifier} = 3'b000;
    tick(3);
    for (int i = 0; i < 10; i++) key(DG, 6'(i), 8'h00, 8'h00, 8'h30 + 8'(i));
    key(kme_pkg::KME_KEY_SYMBOL, 6'h00, 8'h5B, 8'h7B, 8'h5B);
    key(kme_pkg::KME_KEY_FUNC, 6'h00, 8'h80, 8'h90, 8'h80);
    chk(char_out.alt_code, 16'h0);
    key(LT, 6'h1A, 8'h00, 8'h00, 8'h00, 0);
    key(MD, kme_pkg::KME_MODE_UPPER, 8'h00, 8'h00, 8'h00, 0);
    key(LT, 6'h01, 8'h00, 8'h00, 8'h42);
    key(DG, 6'h05, 8'h00, 8'h25, 8'h35);
    key_in.press = 0;
    chk(uppercase_latch, 16'h1);
    shift_held = 1;
    tick(3);
    key(kme_pkg::KME_KEY_SYMBOL, 6'h00, 8'h5B, 8'h7B, 8'h7B);
    key(DG, 6'h01, 8'h00, 8'h21, 8'h21);
    key(kme_pkg::KME_KEY_FUNC, 6'h00, 8'h80, 8'h90, 8'h90);
    chk(char_out.alt_code, 16'h1);
    key_in.press = 0;
    control_held = 1;
    tick(3);
    key(LT, 6'h19, 8'h00, 8'h00, 8'h1A);
    key(MD, kme_pkg::KME_MODE_UPPER, 8'h00, 8'h00, 8'h00, 0);
    key(MD, kme_pkg::KME_MODE_ALTERNATE, 8'h00, 8'h00, 8'h00, 0);
    {control_held, shift_held} = 2'b00;
    key(MD, kme_pkg::KME_MODE_KEYPAD, 8'h00, 8'h00, 8'h00, 0);
    key_in.press = 0;
    tick(3);
    chk({uppercase_latch, keypad_hex_mode}, 16'h1);
    $display("modes done");
    key(LT, 6'h00, 8'h00, 8'h00, 8'h61);
    key_in.press = 0;
    chk(click, 16'h1);
    tick(15);
    chk(click, 16'h1);
    tick(1);
    chk(click, 16'h0);
    key(MD, kme_pkg::KME_MODE_CLACKER, 8'h00, 8'h00, 8'h00, 0);
    key_in.press = 0;
    tick(17);
    key(LT, 6'h00, 8'h00, 8'h00, 8'h61);
    key_in.press = 0;
    chk({clacker_up, click}, 16'h0);
    tick(2);
    chk(n_rx, 16'(n_exp));
    chk(last_code, 8'h61);
    rst = 1;
    tick(1);
    rst = 0;
    chk({keypad_hex_mode, clacker_up}, 16'h1);
    $display("click and reset done");
    results();
  end
endmodule // kme_encoder_test
bind kme_encoder kme_encoder_assertions i_chk (
  .sys_clk            (sys_clk),
  .rst                (rst),
  .control_held       (control_held),
  .shift_held         (shift_held),
  .alternate_modifier (alternate_modifier),
  .key_in             (key_in),
  .char_out           (char_out),
  .uppercase_latch    (uppercase_latch),
  .keypad_hex_mode    (keypad_hex_mode),
  .clacker_up         (clacker_up),
  .click              (click)
);
`default_nettype wire
